/* File: core/occ_gpio_pkg.sv */
// Constants for the overcurrent flag and pin readback register group.
// Assumes the serial register front end hands over decoded register accesses.
//
// Functional notes
// - Channel A high persistence clears flag bit 3
// - Channel A low persistence clears flag bit 2
// - Channel B high persistence clears flag bit 1
// - Channel B low persistence clears flag bit 0
// - Flags idle at one; writing one restores
// - Flag register bits 15:4 read zero
// - Two-bit codes classify static levels and duty bands
// - Main readback packs pins 4..0, upper zero
// - Codes update only in digital pin modes
// - Aux readback packs 1A,0A,1B,0B, gaps zero
// - Flag register at 06h, resets to 000Fh
package occ_gpio_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0]  ADDR_FAULT_FLAGS     = 8'h06;
   localparam logic [7:0]  ADDR_READBACK_MAIN   = 8'h07;
   localparam logic [7:0]  ADDR_READBACK_AUX    = 8'h08;
   localparam logic [3:0]  FAULT_FLAGS_RESET    = 4'hf;
   localparam logic [15:0] READ_ZERO            = 16'h0000;
   localparam logic [1:0]  CODE_RESET           = 2'h0;

   // ==========================================================
   // Flag bit positions in the fault flag register
   localparam int CHAN_A_HIGH_BIT = 3;
   localparam int CHAN_A_LOW_BIT  = 2;
   localparam int CHAN_B_HIGH_BIT = 1;
   localparam int CHAN_B_LOW_BIT  = 0;
   localparam int FLAG_COUNT      = 4;
   localparam int FLAG_PAD_WIDTH  = 12;

   // ==========================================================
   // Pin indices and readback field gaps
   localparam int PIN_COUNT   = 9;
   localparam int PIN0        = 0;
   localparam int PIN1        = 1;
   localparam int PIN2        = 2;
   localparam int PIN3        = 3;
   localparam int PIN4        = 4;
   localparam int PIN0_SIDE_A = 5;
   localparam int PIN1_SIDE_A = 6;
   localparam int PIN0_SIDE_B = 7;
   localparam int PIN1_SIDE_B = 8;
   localparam int MAIN_PAD_WIDTH    = 6;
   localparam int AUX_HIGH_PAD      = 4;
   localparam int AUX_MID_PAD       = 4;

   // ==========================================================
   // Level codes
   localparam logic [1:0] LEVEL_LOW       = 2'h0;
   localparam logic [1:0] LEVEL_WEAK_LOW  = 2'h1;
   localparam logic [1:0] LEVEL_WEAK_HIGH = 2'h2;
   localparam logic [1:0] LEVEL_HIGH      = 2'h3;

   // ==========================================================
   // Duty measurement window, in ref_clk cycles (8-bit counter wraps)
   localparam logic [7:0]  WINDOW_LAST    = 8'hff;
   localparam logic [7:0]  WINDOW_START   = 8'h00;
   localparam logic [10:0] WINDOW_CYCLES  = 11'h100;
   localparam logic [8:0]  HIGH_CNT_ZERO  = 9'h000;

   // ==========================================================
   // Persistence counter
   localparam logic [3:0]  PERSIST_ZERO   = 4'h0;
   localparam logic [3:0]  PERSIST_MIN    = 4'h1;

endpackage

/* File: core/occ_gpio_regs.sv */
// Overcurrent fault flag register and pin level readback registers.
// Assumes synchronous inputs on ref_clk and one-cycle register strobes.
`timescale 1ns/100ps

// ==========================================================
// Persistence counter: flags a fault after N consecutive conversions
module fault_persist
(
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       conv_done,
   input  wire logic       beyond_limit,
   input  wire logic [3:0] count_setting,
   output wire logic       fault_pulse
);
   logic [3:0] count_reg;
   logic [3:0] count_next;
   logic [3:0] target;
   logic [4:0] count_plus;
   logic       hit;

   // A zero setting behaves as a single conversion
   assign target     = (count_setting == occ_gpio_pkg::PERSIST_ZERO) ?
                       occ_gpio_pkg::PERSIST_MIN : count_setting;
   assign count_plus = {1'b0, count_reg} + 5'h01;
   assign hit        = conv_done & beyond_limit & (count_plus >= {1'b0, target});
   assign fault_pulse = hit;
   assign count_next = !conv_done    ? count_reg :
                       !beyond_limit ? occ_gpio_pkg::PERSIST_ZERO :
                       hit           ? target : count_plus[3:0];

   // Run length of conversions beyond the threshold
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         count_reg <= occ_gpio_pkg::PERSIST_ZERO;
      else
         count_reg <= count_next;
   end
endmodule // fault_persist

// ==========================================================
// Duty classifier for one pin over a shared measurement window
module pin_level_sense
(
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       pin_level,
   input  wire logic       digital_mode,
   input  wire logic       window_end,
   output logic      [1:0] level_code
);
   logic [8:0]  high_cnt_reg;
   logic [8:0]  high_cnt_next;
   logic [10:0] high_total;
   logic [10:0] low_total;
   logic [12:0] high_x3;
   logic [12:0] low_x3;
   logic [12:0] window_x2;
   logic [11:0] high_x2;
   logic [1:0]  code_next;

   assign high_total = {2'h0, high_cnt_reg} + {10'h000, pin_level};
   assign low_total  = occ_gpio_pkg::WINDOW_CYCLES - high_total;
   assign high_x3    = {2'h0, high_total} * 13'h0003;
   assign low_x3     = {2'h0, low_total} * 13'h0003;
   assign window_x2  = {1'b0, occ_gpio_pkg::WINDOW_CYCLES, 1'b0};
   assign high_x2    = {high_total, 1'b0};
   assign high_cnt_next = window_end ? occ_gpio_pkg::HIGH_CNT_ZERO : high_total[8:0];

   // High above two thirds, high above half, low above two thirds, else weak low
   assign code_next = (high_x3 > window_x2)                    ? occ_gpio_pkg::LEVEL_HIGH :
                      (high_x2 > {1'b0, occ_gpio_pkg::WINDOW_CYCLES}) ? occ_gpio_pkg::LEVEL_WEAK_HIGH :
                      (low_x3 > window_x2)                     ? occ_gpio_pkg::LEVEL_LOW :
                                                                 occ_gpio_pkg::LEVEL_WEAK_LOW;

   // High-time accumulation across the window
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         high_cnt_reg <= occ_gpio_pkg::HIGH_CNT_ZERO;
      else
         high_cnt_reg <= high_cnt_next;
   end

   // Code refresh at window end, held while the pin is not digital
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         level_code <= occ_gpio_pkg::CODE_RESET;
      else if (window_end && digital_mode)
         level_code <= code_next;
   end
endmodule // pin_level_sense

// ==========================================================
// Register group top
module occ_gpio_regs
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr_en,
   input  wire logic [15:0] reg_wr_data,
   input  wire logic        reg_rd_en,
   output logic      [15:0] reg_rd_data,
   input  wire logic        current_chan_a_conv_done,
   input  wire logic        current_chan_a_above_high,
   input  wire logic        current_chan_a_below_low,
   input  wire logic [3:0]  current_chan_a_fault_count,
   input  wire logic        current_chan_b_conv_done,
   input  wire logic        current_chan_b_above_high,
   input  wire logic        current_chan_b_below_low,
   input  wire logic [3:0]  current_chan_b_fault_count,
   input  wire logic [8:0]  pin_level,
   input  wire logic [8:0]  pin_digital_mode,
   output wire logic        chan_a_high_fault_n,
   output wire logic        chan_a_low_fault_n,
   output wire logic        chan_b_high_fault_n,
   output wire logic        chan_b_low_fault_n
);
   logic [3:0]  fault_flags_reg;
   logic [3:0]  fault_flags_next;
   logic [3:0]  fault_event;
   logic [3:0]  flag_clear;
   logic [7:0]  window_cnt_reg;
   logic        window_end;
   logic [1:0]  level_code [occ_gpio_pkg::PIN_COUNT];
   logic [15:0] flags_word;
   logic [15:0] main_word;
   logic [15:0] aux_word;
   logic [15:0] rd_next;
   logic        sel_flags;

   // ==========================================================
   // Overcurrent persistence detection per comparator
   fault_persist u_a_high
   (
      .ref_clk       (ref_clk),
      .reset         (reset),
      .conv_done     (current_chan_a_conv_done),
      .beyond_limit  (current_chan_a_above_high),
      .count_setting (current_chan_a_fault_count),
      .fault_pulse   (fault_event[occ_gpio_pkg::CHAN_A_HIGH_BIT])
   );
   fault_persist u_a_low
   (
      .ref_clk       (ref_clk),
      .reset         (reset),
      .conv_done     (current_chan_a_conv_done),
      .beyond_limit  (current_chan_a_below_low),
      .count_setting (current_chan_a_fault_count),
      .fault_pulse   (fault_event[occ_gpio_pkg::CHAN_A_LOW_BIT])
   );
   fault_persist u_b_high
   (
      .ref_clk       (ref_clk),
      .reset         (reset),
      .conv_done     (current_chan_b_conv_done),
      .beyond_limit  (current_chan_b_above_high),
      .count_setting (current_chan_b_fault_count),
      .fault_pulse   (fault_event[occ_gpio_pkg::CHAN_B_HIGH_BIT])
   );
   fault_persist u_b_low
   (
      .ref_clk       (ref_clk),
      .reset         (reset),
      .conv_done     (current_chan_b_conv_done),
      .beyond_limit  (current_chan_b_below_low),
      .count_setting (current_chan_b_fault_count),
      .fault_pulse   (fault_event[occ_gpio_pkg::CHAN_B_LOW_BIT])
   );

   // ==========================================================
   // Sticky flags: a fault wins over a same-cycle clear
   assign sel_flags  = (reg_addr == occ_gpio_pkg::ADDR_FAULT_FLAGS);
   assign flag_clear = (reg_wr_en && sel_flags) ?
                       reg_wr_data[occ_gpio_pkg::FLAG_COUNT-1:0] : 4'h0;
   assign fault_flags_next = (fault_flags_reg | flag_clear) & ~fault_event;

   // Flag storage, idle high after reset
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         fault_flags_reg <= occ_gpio_pkg::FAULT_FLAGS_RESET;
      else
         fault_flags_reg <= fault_flags_next;
   end

   assign chan_a_high_fault_n = fault_flags_reg[occ_gpio_pkg::CHAN_A_HIGH_BIT];
   assign chan_a_low_fault_n  = fault_flags_reg[occ_gpio_pkg::CHAN_A_LOW_BIT];
   assign chan_b_high_fault_n = fault_flags_reg[occ_gpio_pkg::CHAN_B_HIGH_BIT];
   assign chan_b_low_fault_n  = fault_flags_reg[occ_gpio_pkg::CHAN_B_LOW_BIT];

   // ==========================================================
   // Shared duty window counter
   assign window_end = (window_cnt_reg == occ_gpio_pkg::WINDOW_LAST);

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         window_cnt_reg <= occ_gpio_pkg::WINDOW_START;
      else
         window_cnt_reg <= window_cnt_reg + 8'h01;
   end

   // One classifier per pin
   for (genvar i = 0; i < occ_gpio_pkg::PIN_COUNT; i++)
   begin : g_pin
      pin_level_sense u_sense
      (
         .ref_clk      (ref_clk),
         .reset        (reset),
         .pin_level    (pin_level[i]),
         .digital_mode (pin_digital_mode[i]),
         .window_end   (window_end),
         .level_code   (level_code[i])
      );
   end

   // ==========================================================
   // Read words with reserved bits forced to zero
   assign flags_word = {{occ_gpio_pkg::FLAG_PAD_WIDTH{1'b0}}, fault_flags_reg};
   assign main_word  = {{occ_gpio_pkg::MAIN_PAD_WIDTH{1'b0}},
                        level_code[occ_gpio_pkg::PIN4], level_code[occ_gpio_pkg::PIN3],
                        level_code[occ_gpio_pkg::PIN2], level_code[occ_gpio_pkg::PIN1],
                        level_code[occ_gpio_pkg::PIN0]};
   assign aux_word   = {{occ_gpio_pkg::AUX_HIGH_PAD{1'b0}},
                        level_code[occ_gpio_pkg::PIN1_SIDE_A],
                        level_code[occ_gpio_pkg::PIN0_SIDE_A],
                        {occ_gpio_pkg::AUX_MID_PAD{1'b0}},
                        level_code[occ_gpio_pkg::PIN1_SIDE_B],
                        level_code[occ_gpio_pkg::PIN0_SIDE_B]};
   assign rd_next = sel_flags ? flags_word :
                    (reg_addr == occ_gpio_pkg::ADDR_READBACK_MAIN) ? main_word :
                    (reg_addr == occ_gpio_pkg::ADDR_READBACK_AUX)  ? aux_word :
                    occ_gpio_pkg::READ_ZERO;

   // Read data captured on the read strobe
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         reg_rd_data <= occ_gpio_pkg::READ_ZERO;
      else if (reg_rd_en)
         reg_rd_data <= rd_next;
   end
endmodule // occ_gpio_regs

/* File: verification/host_model.sv */
// Host side of the register strobe port: one write task, one read task.
// Assumes the bench calls the tasks and the design answers reads a cycle later.
`timescale 1ns/100ps
module host_model
(
   input  wire logic        ref_clk,
   output logic      [7:0]  reg_addr,
   output logic             reg_wr_en,
   output logic      [15:0] reg_wr_data,
   output logic             reg_rd_en,
   input  wire logic [15:0] reg_rd_data
);
   // ==========================================================
   // Idle bus at time zero
   initial
   begin
      reg_addr = 8'h00;
      reg_wr_en = 1'b0;
      reg_wr_data = 16'h0000;
      reg_rd_en = 1'b0;
   end

   // Write strobe for one rising edge, then stale data is inverted
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
   begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      @(negedge ref_clk);
      reg_wr_en = 1'b0;
      reg_wr_data = ~d;
   end
   endtask

   // Read strobe for one rising edge; data is settled by the next falling edge
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
   begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge ref_clk);
      reg_rd_en = 1'b0;
      d = reg_rd_data;
   end
   endtask
endmodule // host_model

/* File: verification/occ_gpio_regs_assertions.sv */
// Checker for the fault flag and pin readback register group.
// Assumes it is bound to occ_gpio_regs and sees only that module's ports.
`timescale 1ns/100ps
module occ_gpio_checker
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr_en,
   input  wire logic [15:0] reg_wr_data,
   input  wire logic        reg_rd_en,
   input  wire logic [15:0] reg_rd_data,
   input  wire logic        current_chan_a_conv_done,
   input  wire logic        current_chan_a_above_high,
   input  wire logic        current_chan_a_below_low,
   input  wire logic        current_chan_b_conv_done,
   input  wire logic        current_chan_b_above_high,
   input  wire logic        current_chan_b_below_low,
   input  wire logic        chan_a_high_fault_n,
   input  wire logic        chan_a_low_fault_n,
   input  wire logic        chan_b_high_fault_n,
   input  wire logic        chan_b_low_fault_n
);
   // ==========================================================
   // Flag vector and host clear mask
   logic [3:0] flags;
   logic [3:0] clr;
   assign flags = {chan_a_high_fault_n, chan_a_low_fault_n, chan_b_high_fault_n, chan_b_low_fault_n};
   assign clr   = (reg_wr_en && reg_addr == 8'h06) ? reg_wr_data[3:0] : 4'h0;

   a_reset_flags: assert property (@(posedge ref_clk) reset |=> flags == 4'hf && reg_rd_data == 16'h0000)
      else $error("flags or read data not at reset value");
   a_flag_sticky: assert property (@(posedge ref_clk) disable iff (reset) 1'b1 |=> ((~$past(flags) & ~$past(clr)) & flags) == 4'h0)
      else $error("fault flag rose without a host clear");
   a_clear_restores: assert property (@(posedge ref_clk) disable iff (reset) clr[3] && !(current_chan_a_conv_done && current_chan_a_above_high) |=> flags[3])
      else $error("clear of channel a high flag had no effect");
   a_a_high_cause: assert property (@(posedge ref_clk) disable iff (reset) $fell(flags[3]) |-> $past(current_chan_a_conv_done && current_chan_a_above_high))
      else $error("channel a high flag fell without a qualifying conversion");
   a_a_low_cause: assert property (@(posedge ref_clk) disable iff (reset) $fell(flags[2]) |-> $past(current_chan_a_conv_done && current_chan_a_below_low))
      else $error("channel a low flag fell without a qualifying conversion");
   a_b_high_cause: assert property (@(posedge ref_clk) disable iff (reset) $fell(flags[1]) |-> $past(current_chan_b_conv_done && current_chan_b_above_high))
      else $error("channel b high flag fell without a qualifying conversion");
   a_b_low_cause: assert property (@(posedge ref_clk) disable iff (reset) $fell(flags[0]) |-> $past(current_chan_b_conv_done && current_chan_b_below_low))
      else $error("channel b low flag fell without a qualifying conversion");
   a_flag_read: assert property (@(posedge ref_clk) disable iff (reset) reg_rd_en && reg_addr == 8'h06 |=> reg_rd_data == {12'h000, $past(flags)})
      else $error("flag register read does not match flags");
   a_main_pad: assert property (@(posedge ref_clk) disable iff (reset) reg_rd_en && reg_addr == 8'h07 |=> reg_rd_data[15:10] == 6'h00)
      else $error("main readback upper bits not zero");
   a_aux_pad: assert property (@(posedge ref_clk) disable iff (reset) reg_rd_en && reg_addr == 8'h08 |=> reg_rd_data[15:12] == 4'h0 && reg_rd_data[7:4] == 4'h0)
      else $error("aux readback gap bits not zero");
endmodule // occ_gpio_checker

bind occ_gpio_regs occ_gpio_checker i_checker
(
   .ref_clk, .reset, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
   .current_chan_a_conv_done, .current_chan_a_above_high, .current_chan_a_below_low,
   .current_chan_b_conv_done, .current_chan_b_above_high, .current_chan_b_below_low,
   .chan_a_high_fault_n, .chan_a_low_fault_n, .chan_b_high_fault_n, .chan_b_low_fault_n
);

/* File: verification/occ_gpio_regs_tb.sv */
// Self-checking bench for the fault flag and pin readback register group.
// Assumes the package, design, checker and host model are compiled first.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module occ_gpio_regs_tb;
   logic        ref_clk, reset, a_done, a_hi, a_lo, b_done, b_hi, b_lo, all_high;
   logic [3:0]  n_conv;
   logic [8:0]  pin_level, pin_mode;
   logic [15:0] got;
   wire  [7:0]  reg_addr;
   wire         reg_wr_en, reg_rd_en;
   wire  [15:0] reg_wr_data, reg_rd_data;
   wire  [3:0]  fault_n;
   int          n_fail, check_count, ph;

   // ==========================================================
   // Clock, pin patterns: per pin static low, 60% low, 60% high, static high
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(negedge ref_clk)
   begin
      ph = (ph + 1) % 5;
      pin_level = all_high ? 9'h1ff : {2'h3, ph < 3, ph >= 3, 2'h1, ph < 3, ph >= 3, 1'b0};
   end

   host_model i_host (.ref_clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data);
   occ_gpio_regs i_dut (.ref_clk, .reset, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
      .reg_rd_data, .current_chan_a_conv_done(a_done), .current_chan_a_above_high(a_hi),
      .current_chan_a_below_low(a_lo), .current_chan_a_fault_count(n_conv),
      .current_chan_b_conv_done(b_done), .current_chan_b_above_high(b_hi),
      .current_chan_b_below_low(b_lo), .current_chan_b_fault_count(n_conv),
      .pin_level, .pin_digital_mode(pin_mode), .chan_a_high_fault_n(fault_n[3]),
      .chan_a_low_fault_n(fault_n[2]), .chan_b_high_fault_n(fault_n[1]),
      .chan_b_low_fault_n(fault_n[0]));

   // Read one register and compare
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
   begin
      i_host.rd(a, got);
      `CHK($sformatf("reg %h", a), e, got)
   end
   endtask
   // One conversion on the channel owning flag k; q makes it qualify
   task automatic conv(input int k, input logic q);
   begin
      @(negedge ref_clk);
      a_done = k > 1;
      b_done = k < 2;
      a_hi = q && k == 3;
      a_lo = q && k == 2;
      b_hi = q && k == 1;
      b_lo = q && k == 0;
      @(negedge ref_clk);
      a_done = 1'b0;
      b_done = 1'b0;
   end
   endtask
   task automatic wrap_up;
   begin
      $display("Counts: %0d checks, %0d mismatches", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask

   // ==========================================================
   // Main sequence and hang guard
   initial
   begin
      {reset, a_done, a_hi, a_lo, b_done, b_hi, b_lo, all_high} = 8'h80;
      {n_fail, check_count, ph, pin_level, pin_mode, n_conv} = {96'h0, 9'h0, 9'h0ff, 4'h2};
      repeat (6) @(negedge ref_clk);
      reset = 1'b0;
      rd_chk(8'h06, 16'h000f);
      rd_chk(8'h09, 16'h0000);
      i_host.wr(8'h07, 16'hffff);
      rd_chk(8'h07, 16'h0000);
      $display("Test reset values done");
      for (int k = 3; k >= 0; k--)
      begin
         conv(k, 1'b1);
         conv(k, 1'b0);
         conv(k, 1'b1);
         rd_chk(8'h06, 16'h000f);
         conv(k, 1'b1);
         conv(k, 1'b0);
         i_host.wr(8'h06, 16'hfff0);
         rd_chk(8'h06, 16'h000f ^ (16'h0001 << k));
         `CHK("fault_n", 4'hf ^ (4'h1 << k), fault_n)
         i_host.wr(8'h06, 16'h0001 << k);
         rd_chk(8'h06, 16'h000f);
         `CHK("fault_n", 4'hf, fault_n)
      end
      // Single-conversion setting, then a mid-run reset restores idle flags
      n_conv = 4'h1;
      conv(3, 1'b1);
      `CHK("fault_n", 4'h7, fault_n)
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      rd_chk(8'h06, 16'h000f);
      `CHK("fault_n", 4'hf, fault_n)
      $display("Test fault flags done");
      repeat (520) @(negedge ref_clk);
      rd_chk(8'h07, 16'h00e4);
      rd_chk(8'h08, 16'h0903);
      pin_mode = 9'h000;
      all_high = 1'b1;
      repeat (300) @(negedge ref_clk);
      rd_chk(8'h07, 16'h00e4);
      pin_mode = 9'h1ff;
      repeat (520) @(negedge ref_clk);
      rd_chk(8'h07, 16'h03ff);
      rd_chk(8'h08, 16'h0f0f);
      $display("Test pin readback done");
      wrap_up();
   end
   initial
   begin
      #1000000;
      n_fail++;
      wrap_up();
   end
endmodule // occ_gpio_regs_tb
